// ### include/fcclr_link_if.sv
`timescale 1ns/1ns
interface fcclr_link_if;
  import fcclr_pkg::*;
  logic link_clk;
  logic [WORD_W-1:0] link_data;
  logic master_src_accel;
  modport tx (output link_clk, output link_data, output master_src_accel);
  modport rx (input link_clk, input link_data, input master_src_accel);
endinterface

// ### include/fcclr_pkg.sv
package fcclr_pkg;
  // link word layout: four control bits, slow clock copy, three spare
  localparam int WORD_W = 8;
  localparam int CTL_W = 4;
  localparam int CTL_LSB = 0;
  localparam int SLOW_BIT = 4;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [CTL_W-1:0] CTL_RST = 4'h0;
  // control bit order inside the control field
  localparam int CTL_RUN = 0;
  localparam int CTL_LATCH = 1;
  localparam int CTL_HALT = 2;
  localparam int CTL_SPARE = 3;
  // clock mux sources
  localparam int NUM_CLK = 5;
  localparam int CLK_SEL_W = 3;
  localparam logic [CLK_SEL_W-1:0] CLK_SEL_RST = 3'h0;
  localparam logic [CLK_SEL_W-1:0] CLK_SEL_LINK_FAST = 3'h3;
  localparam logic [CLK_SEL_W-1:0] CLK_SEL_LINK_SLOW = 3'h4;
  // link clock from the master: core clock divided, two link cycles per slow cycle
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int LINK_HALF_CYC = 2;
  localparam logic [1:0] LINK_HALF_CYC_M1 = 2'(LINK_HALF_CYC - 1);
  // lock supervision
  localparam int LOCK_WAIT_NS = 20_000;
  localparam int LOCK_WAIT_CYC = (LOCK_WAIT_NS * (CORE_CLK_HZ / 1_000_000)) / 1000;
  localparam logic [11:0] LOCK_WAIT_CNT = 12'(LOCK_WAIT_CYC);
  // reference oscillator choice
  typedef enum logic {FCCLR_REF_LOCAL_20M, FCCLR_REF_ACCEL_18M} fcclr_ref_t;
  typedef enum logic [1:0] {FCCLR_RESET, FCCLR_WAIT, FCCLR_LOCKED} fcclr_state_t;
endpackage

// ### src/fcclr_rx.sv
// Operation
// [R1] link clock runs twice the slow clock
// [R2] one eight-bit word per link cycle
// [R3] four word bits carry control signals
// [R4] one word bit carries slow clock copy
// [R5] provide fast and slow recovered clocks
// [R6] reference from crystal within tolerance
// [R7] link clock 20MHz or 18.766MHz by source
// [R8] enable exactly one reference oscillator
// [R9] data bits aligned to recovered clock
// [R10] process data on recovered clock edges
// [R11] drive deserializer controls, read its status
// [R12] internal mux picks one of five clocks
// [R13] mux path skew left to channel delays
// [R14] control mux follows clock selection
// [R15] mux switching glitches are tolerated
// [R16] controls aligned to slow clock edges
`timescale 1ns/1ns
module fcclr_rx (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // link from master
  fcclr_link_if.rx link,
  // deserializer status
  input wire logic i_rx_violation,
  input wire logic i_rx_locked,
  // local clock and control sources
  input wire logic [fcclr_pkg::NUM_CLK-1:0] i_clk_src,
  input wire logic [fcclr_pkg::CTL_W-1:0] i_local_ctl,
  input wire logic [fcclr_pkg::CLK_SEL_W-1:0] i_clk_sel,
  // reference oscillator enables
  output logic o_ref_en_20m,
  output logic o_ref_en_18m,
  // deserializer controls
  output logic o_rx_reset,
  output logic o_rx_enable,
  // recovered signals
  output logic o_fast_clk,
  output logic o_slow_clk,
  output logic [fcclr_pkg::CTL_W-1:0] o_link_ctl,
  output logic o_link_up,
  output logic o_err,
  // muxed outputs
  output logic o_mux_clk,
  output logic [fcclr_pkg::CTL_W-1:0] o_mux_ctl
);
  import fcclr_pkg::*;

  logic [WORD_W+2-1:0] link_s;
  logic [NUM_CLK+2-1:0] misc_s;
  logic lclk_s;
  logic [WORD_W-1:0] ldata_s;
  logic accel_s;
  logic viol_s;
  logic lock_s;
  logic [NUM_CLK-1:0] clk_s;

  // pins from other domains pass two flops before use
  fcclr_sync #(.W(WORD_W + 2)) u_sync_link (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_async({link.link_clk, link.master_src_accel, link.link_data}),
    .o_sync(link_s)
  );
  fcclr_sync #(.W(NUM_CLK + 2)) u_sync_misc (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_async({i_rx_violation, i_rx_locked, i_clk_src}),
    .o_sync(misc_s)
  );
  assign lclk_s = link_s[WORD_W+1];
  assign accel_s = link_s[WORD_W];
  assign ldata_s = link_s[WORD_W-1:0];
  assign viol_s = misc_s[NUM_CLK+1];
  assign lock_s = misc_s[NUM_CLK];
  assign clk_s = misc_s[NUM_CLK-1:0];

  typedef struct packed {
    fcclr_state_t state;
    logic [11:0] wait_cnt;
    fcclr_ref_t ref_sel;
    logic lclk_prev;
    logic [WORD_W-1:0] word;
    logic slow_prev;
    logic fast;
    logic slow;
    logic [CTL_W-1:0] ctl;
    logic ref20;
    logic ref18;
    logic rst;
    logic en;
    logic up;
    logic err;
    logic mclk;
    logic [CTL_W-1:0] mctl;
  } fcclr_rx_st_t;

  fcclr_rx_st_t st_q;
  fcclr_rx_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.lclk_prev = lclk_s;
    // reference follows the master's source; crystal tolerance is a board matter
    st_d.ref_sel = accel_s ? FCCLR_REF_ACCEL_18M : FCCLR_REF_LOCAL_20M; // R7 R6
    st_d.ref18 = (st_d.ref_sel == FCCLR_REF_ACCEL_18M); // R8
    st_d.ref20 = (st_d.ref_sel != FCCLR_REF_ACCEL_18M); // R8
    st_d.fast = lclk_s; // R5
    // word captured on the rising recovered edge, where data is stable
    if (lclk_s && !st_q.lclk_prev) begin
      st_d.word = ldata_s; // R9 R10 R2
      st_d.slow_prev = ldata_s[SLOW_BIT];
      st_d.slow = ldata_s[SLOW_BIT]; // R4 R5
      // controls update only on slow clock rising edges
      if (ldata_s[SLOW_BIT] && !st_q.slow_prev) begin
        st_d.ctl = ldata_s[CTL_LSB +: CTL_W]; // R3 R16
      end
    end
    // deserializer control sequencing
    case (st_q.state)
      FCCLR_RESET: begin
        st_d.rst = 1'h1; // R11
        st_d.en = 1'h0;
        st_d.up = 1'h0;
        st_d.wait_cnt = LOCK_WAIT_CNT;
        st_d.state = FCCLR_WAIT;
      end
      FCCLR_WAIT: begin
        st_d.rst = 1'h0;
        st_d.en = 1'h1; // R11
        if (st_q.wait_cnt != 12'h000) begin
          st_d.wait_cnt = st_q.wait_cnt - 12'h001;
        end else if (lock_s) begin
          st_d.state = FCCLR_LOCKED;
        end
      end
      FCCLR_LOCKED: begin
        st_d.up = 1'h1;
        if (!lock_s) begin
          st_d.state = FCCLR_RESET; // R11
        end
      end
      default: begin
        st_d.state = FCCLR_RESET;
      end
    endcase
    // sticky until reset; reset clears it even while a violation is present
    st_d.err = st_q.err | viol_s; // R11
    // reference switch forces a relock
    if (st_d.ref_sel != st_q.ref_sel) begin
      st_d.state = FCCLR_RESET;
    end
    // five-way clock mux; a switch may glitch, the downstream pll smooths it
    // a single output flop shared by all sources, residual skew is trimmed per channel
    case (i_clk_sel) // R13
      3'h0: st_d.mclk = clk_s[0]; // R12 R15
      3'h1: st_d.mclk = clk_s[1];
      3'h2: st_d.mclk = clk_s[2];
      CLK_SEL_LINK_FAST: st_d.mclk = st_q.fast;
      CLK_SEL_LINK_SLOW: st_d.mclk = st_q.slow;
      default: st_d.mclk = clk_s[0];
    endcase
    // control source goes with the clock source
    if (i_clk_sel == CLK_SEL_LINK_FAST || i_clk_sel == CLK_SEL_LINK_SLOW) begin
      st_d.mctl = st_q.ctl; // R14
    end else begin
      st_d.mctl = i_local_ctl; // R14
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '0;
      st_q.state <= FCCLR_RESET;
      st_q.ref20 <= 1'h1;
      st_q.rst <= 1'h1;
      st_q.ctl <= CTL_RST;
      st_q.mctl <= CTL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_ref_en_20m = st_q.ref20;
  assign o_ref_en_18m = st_q.ref18;
  assign o_rx_reset = st_q.rst;
  assign o_rx_enable = st_q.en;
  assign o_fast_clk = st_q.fast;
  assign o_slow_clk = st_q.slow;
  assign o_link_ctl = st_q.ctl;
  assign o_link_up = st_q.up;
  assign o_err = st_q.err;
  assign o_mux_clk = st_q.mclk;
  assign o_mux_ctl = st_q.mctl;
endmodule

// ### src/fcclr_sync.sv
`timescale 1ns/1ns
module fcclr_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } fcclr_sync_st_t;
  fcclr_sync_st_t st_q;
  fcclr_sync_st_t st_d;
  always_comb begin
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_sync = st_q.sync;
endmodule

// ### src/fcclr_tx.sv
`timescale 1ns/1ns
module fcclr_tx (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // user side
  input wire logic [fcclr_pkg::CTL_W-1:0] i_ctl,
  input wire logic i_src_accel,
  // link
  fcclr_link_if.tx link
);
  import fcclr_pkg::*;
  typedef struct packed {
    logic [1:0] div;
    logic fast;
    logic slow;
    logic [WORD_W-1:0] word;
    logic accel;
  } fcclr_tx_st_t;
  fcclr_tx_st_t st_q;
  fcclr_tx_st_t st_d;
  always_comb begin
    st_d = st_q;
    st_d.accel = i_src_accel;
    st_d.div = st_q.div + 2'h1;
    if (st_q.div == LINK_HALF_CYC_M1) begin
      st_d.div = 2'h0;
      st_d.fast = ~st_q.fast;
      // new word on each falling link edge, stable around the rising one
      if (st_q.fast) begin
        // link clock at twice the slow clock rate
        st_d.slow = ~st_q.slow; // R1
        st_d.word = WORD_RST; // R2
        st_d.word[CTL_LSB +: CTL_W] = i_ctl; // R3
        st_d.word[SLOW_BIT] = ~st_q.slow; // R4
      end
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign link.link_clk = st_q.fast;
  assign link.link_data = st_q.word;
  assign link.master_src_accel = st_q.accel;
endmodule

// ### tb/fcclr_link_assertions.sv
`timescale 1ns/1ns
module fcclr_link_assertions (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // link wire
  input wire logic i_link_clk,
  input wire logic [fcclr_pkg::WORD_W-1:0] i_link_data,
  input wire logic i_master_src_accel
);
  import fcclr_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  property p_half_hold; $changed(i_link_clk) |=> $stable(i_link_clk); endproperty
  a_half_hold: assert property (p_half_hold) else $error("link clock half too short");
  property p_high_len; $rose(i_link_clk) |-> ##2 $fell(i_link_clk); endproperty
  a_high_len: assert property (p_high_len) else $error("link clock high phase wrong");
  property p_low_len; $fell(i_link_clk) |-> ##2 $rose(i_link_clk); endproperty
  a_low_len: assert property (p_low_len) else $error("link clock low phase wrong");
  property p_word_edge; $changed(i_link_data) |-> $fell(i_link_clk); endproperty
  a_word_edge: assert property (p_word_edge) else $error("word changed off link edge");
  property p_word_hold; $fell(i_link_clk) |=> $stable(i_link_data)[*3]; endproperty
  a_word_hold: assert property (p_word_hold) else $error("word not held a link period");
  property p_spare; i_link_data[WORD_W-1:SLOW_BIT+1] == 3'h0; endproperty
  a_spare: assert property (p_spare) else $error("unused word bits not zero");
  property p_slow_tgl; $fell(i_link_clk) |-> $changed(i_link_data[SLOW_BIT]); endproperty
  a_slow_tgl: assert property (p_slow_tgl) else $error("slow copy missed a toggle");
  property p_slow_per;
    $rose(i_link_data[SLOW_BIT]) |-> ##8 $rose(i_link_data[SLOW_BIT]);
  endproperty
  a_slow_per: assert property (p_slow_per) else $error("slow copy period wrong");
endmodule

// ### tb/fiber_clock_control_link_rx_tb.sv
`timescale 1ns/1ns
module fiber_clock_control_link_rx_tb;
  import fcclr_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [CTL_W-1:0] ctl = 4'h0, lctl = 4'h0, c, l;
  logic accel = 1'b0, viol = 1'b0, lock = 1'b0;
  logic [NUM_CLK-1:0] src = 5'h00;
  logic [CLK_SEL_W-1:0] sel = 3'h0;
  logic ref20, ref18, rxr, rxe, fck, sck, up, err, mck, fp, sp, mp, rp;
  logic [CTL_W-1:0] lk, mx;
  int n_fail = 0, checks_done = 0, seed = 98448, nf = 0, ns = 0, nm = 0, nr = 0;
  logic [CTL_W-1:0] q[$];
  fcclr_link_if lnk ();
  fcclr_tx fcclr_tx_i (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_ctl(ctl),
    .i_src_accel(accel), .link(lnk.tx));
  fcclr_rx fcclr_rx_i (.i_core_clk(i_core_clk), .i_srst(i_srst), .link(lnk.rx),
    .i_rx_violation(viol), .i_rx_locked(lock), .i_clk_src(src), .i_local_ctl(lctl),
    .i_clk_sel(sel), .o_ref_en_20m(ref20), .o_ref_en_18m(ref18), .o_rx_reset(rxr),
    .o_rx_enable(rxe), .o_fast_clk(fck), .o_slow_clk(sck), .o_link_ctl(lk),
    .o_link_up(up), .o_err(err), .o_mux_clk(mck), .o_mux_ctl(mx));
  fcclr_link_assertions chk_i (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_link_clk(lnk.link_clk), .i_link_data(lnk.link_data),
    .i_master_src_accel(lnk.master_src_accel));
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    nf += int'(fck & ~fp);
    ns += int'(sck & ~sp);
    nm += int'(mck & ~mp);
    nr += int'(rxr & ~rp);
    fp <= fck;
    sp <= sck;
    mp <= mck;
    rp <= rxr;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard well beyond the ~3200 cycles the sequence needs
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge i_core_clk);
    chk(8'({ref20, ref18, rxr}), 8'h5);
    i_srst <= 1'b0;
    lock <= 1'b1;
    repeat (150) @(posedge i_core_clk);
    chk(8'(up), 8'h0);
    repeat (100) @(posedge i_core_clk);
    chk(8'({up, rxe, rxr}), 8'h6);
    for (int k = 0; k < 8; k++) begin
      c = 4'($random(seed));
      l = 4'($random(seed));
      q.push_back(c);
      ctl <= c;
      lctl <= l;
      accel <= (k >= 4);
      sel <= 3'(k % NUM_CLK);
      src <= 5'($random(seed));
      // accel change forces a relock, so every step waits out the lock delay
      repeat (260) @(posedge i_core_clk);
      chk(8'({ref20, ref18}), (k >= 4) ? 8'h1 : 8'h2);
      chk(8'(up), 8'h1);
      chk(8'(lnk.link_data[CTL_W-1:0]), 8'(q[$]));
      chk(8'(lk), 8'(q[$]));
      chk(8'(mx), (sel >= CLK_SEL_LINK_FAST) ? 8'(q[$]) : 8'(l));
      if (sel < CLK_SEL_LINK_FAST)
        chk(8'(mck), 8'(src[sel]));
      @(negedge i_core_clk);
      nf = 0;
      ns = 0;
      nm = 0;
      repeat (80) @(negedge i_core_clk);
      chk(8'(nf), 8'h14);
      chk(8'(ns), 8'h0a);
      chk(8'(nm), (sel == 3'h3) ? 8'h14 : (sel == 3'h4) ? 8'h0a : 8'h00);
      $display("test %0d done", k);
    end
    @(posedge i_core_clk);
    viol <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    viol <= 1'b0;
    repeat (20) @(posedge i_core_clk);
    chk(8'(err), 8'h1);
    $display("test violation done");
    // loss of lock drops the link and pulses the receiver reset once
    lock <= 1'h0;
    @(negedge i_core_clk);
    nr = 0;
    repeat (10) @(posedge i_core_clk);
    chk(8'(up), 8'h0);
    lock <= 1'h1;
    repeat (LOCK_WAIT_CYC + 10) @(posedge i_core_clk);
    chk(8'({up, rxe, rxr}), 8'h6);
    chk(8'(nr), 8'h1);
    $display("test relock done");
    i_srst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk(8'({err, rxr}), 8'h1);
    $display("test reset done");
    end_of_test();
  end
endmodule
